// ---- rtl/cci_exec.sv ----
// execution of subroutine call, file register clear, accumulator clear and watchdog restart
// assumes fetch, register file and software port all run on mclk; no resynchronisation needed
//
// Function
// - call pushes program counter plus one onto the return stack head
// - call loads its eight-bit immediate into program counter bits 7 to 0
// - call copies status bits 6 and 5 into program counter bits 10 and 9
// - call clears program counter bit 8, takes two cycles, flags unchanged
// - file register wipe writes 00h to register 0..31, sets zero flag, one cycle
// - accumulator wipe 0000 0100 0000 clears accumulator, sets zero flag, one cycle
// - watchdog restart zeroes counter, and prescaler only when assigned to watchdog
// - watchdog restart sets expiry bit and sleep entry bit to one
`default_nettype none

module cci_exec #(
  parameter int WDT_PRESCALE = cci_pkg::WDT_PRESCALE_DEF,
  parameter logic [10:0] RESET_VECTOR = cci_pkg::PC_RST
) (
  input wire logic mclk,
  input wire logic rstn,
  // instruction from fetch
  input wire logic instr_valid,
  input wire logic [11:0] instr_word,
  output logic instr_ready,
  output logic exec_done,
  output logic [10:0] program_counter,
  // return stack push
  output logic stack_push,
  output logic [10:0] return_stack_head,
  // register file write port
  output logic file_wr_en,
  output logic [4:0] file_wr_addr,
  output logic [7:0] file_wr_data,
  // core state seen by neighbours
  output logic [7:0] accumulator,
  output logic zero_flag,
  output logic watchdog_expiry_bit,
  output logic sleep_entry_bit,
  output logic watchdog_timeout,
  // software register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);

  typedef struct packed {
    cci_pkg::cci_phase_type phase;
    logic [10:0] pc;
    logic [10:0] stack_head;
    logic stack_push;
    logic [7:0] acc;
    logic [7:0] status;
    logic [7:0] control;
    logic file_wr_en;
    logic [4:0] file_wr_addr;
    logic instr_ready;
    logic exec_done;
    logic wdt_restart;
    logic psc_restart;
    logic [7:0] rdata;
  } cci_core_state_type;

  cci_core_state_type s;
  cci_core_state_type next_s;
  logic [7:0] wdt_count;
  logic wdt_timeout;
  logic take;
  logic [11:0] word;

  // watchdog counter and prescaler
  cci_watchdog #(
    .PRESCALE(WDT_PRESCALE)
  ) u_watchdog (
    .mclk(mclk),
    .rstn(rstn),
    .counter_restart(s.wdt_restart),
    .prescaler_restart(s.psc_restart),
    .prescaler_assigned(s.control[cci_pkg::CTL_PSC_WDT]),
    .watchdog_counter(wdt_count),
    .timeout(wdt_timeout)
  );

  // one word per instruction, taken only while ready
  assign take = instr_valid && s.instr_ready;
  assign word = instr_word;

  // next state of the core
  always_comb
  begin
    next_s = s;
    next_s.stack_push = 1'b0;
    next_s.file_wr_en = 1'b0;
    next_s.exec_done = 1'b0;
    next_s.wdt_restart = 1'b0;
    next_s.psc_restart = 1'b0;
    next_s.rdata = 8'h00;

    // software writes come first so hardware updates below win
    if (reg_wr)
    begin
      unique case (reg_addr)
        cci_pkg::REG_STATUS: next_s.status = reg_wdata;
        cci_pkg::REG_CONTROL: next_s.control = reg_wdata;
        cci_pkg::REG_ACCUM: next_s.acc = reg_wdata;
        default: next_s.status = next_s.status; // read-only or unmapped: ignored
      endcase
    end

    // watchdog expiry drops the expiry bit
    if (wdt_timeout)
    begin
      next_s.status[cci_pkg::ST_EXPIRY] = 1'b0;
    end

    // instruction sequencing
    unique case (s.phase)
      cci_pkg::PH_EXEC:
      begin
        if (take)
        begin
          next_s.exec_done = 1'b1;
          next_s.pc = s.pc + 11'h001;
          if (cci_pkg::cci_is_call(word))
          begin
            next_s.stack_head = s.pc + 11'h001;
            next_s.stack_push = 1'b1;
            next_s.pc[cci_pkg::IMM_MSB:cci_pkg::IMM_LSB] = word[cci_pkg::IMM_MSB:cci_pkg::IMM_LSB];
            next_s.pc[cci_pkg::ST_PAGE_HI+4] = s.status[cci_pkg::ST_PAGE_HI];
            next_s.pc[cci_pkg::ST_PAGE_LO+4] = s.status[cci_pkg::ST_PAGE_LO];
            next_s.pc[8] = 1'b0;
            next_s.phase = cci_pkg::PH_CALL_SECOND;
            next_s.instr_ready = 1'b0;
            next_s.exec_done = 1'b0;
          end
          else if (cci_pkg::cci_is_file_wipe(word))
          begin
            next_s.file_wr_en = 1'b1;
            next_s.file_wr_addr = cci_pkg::cci_file_addr(word);
            next_s.status[cci_pkg::ST_ZERO] = 1'b1;
          end
          else if (word == cci_pkg::ACC_WIPE_CODE)
          begin
            next_s.acc = cci_pkg::ACCUM_RST;
            next_s.status[cci_pkg::ST_ZERO] = 1'b1;
          end
          else if (word == cci_pkg::WDT_RESTART_CODE)
          begin
            next_s.wdt_restart = 1'b1;
            next_s.psc_restart = s.control[cci_pkg::CTL_PSC_WDT];
            next_s.status[cci_pkg::ST_EXPIRY] = 1'b1;
            next_s.status[cci_pkg::ST_SLEEP] = 1'b1;
          end
        end
      end
      cci_pkg::PH_CALL_SECOND:
      begin
        // second cycle of a call: no word taken, flags untouched
        next_s.phase = cci_pkg::PH_EXEC;
        next_s.instr_ready = 1'b1;
        next_s.exec_done = 1'b1;
      end
    endcase

    // read data from current state, valid for the following cycle only
    if (reg_rd)
    begin
      unique case (reg_addr)
        cci_pkg::REG_STATUS: next_s.rdata = s.status;
        cci_pkg::REG_CONTROL: next_s.rdata = s.control;
        cci_pkg::REG_ACCUM: next_s.rdata = s.acc;
        cci_pkg::REG_PC_LO: next_s.rdata = s.pc[7:0];
        cci_pkg::REG_PC_HI: next_s.rdata = {5'h00, s.pc[10:8]};
        cci_pkg::REG_STACK_LO: next_s.rdata = s.stack_head[7:0];
        cci_pkg::REG_STACK_HI: next_s.rdata = {5'h00, s.stack_head[10:8]};
        cci_pkg::REG_WDT_COUNT: next_s.rdata = wdt_count;
        default: next_s.rdata = 8'h00; // unmapped reads as zero
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s <= '{
        phase: cci_pkg::PH_EXEC,
        pc: RESET_VECTOR,
        stack_head: 11'h000,
        stack_push: 1'b0,
        acc: cci_pkg::ACCUM_RST,
        status: cci_pkg::STATUS_RST,
        control: cci_pkg::CONTROL_RST,
        file_wr_en: 1'b0,
        file_wr_addr: 5'h00,
        instr_ready: 1'b1,
        exec_done: 1'b0,
        wdt_restart: 1'b0,
        psc_restart: 1'b0,
        rdata: 8'h00
      };
    end
    else
    begin
      s <= next_s;
    end
  end

  // outputs straight from state flops, file write data tied to 00h
  assign instr_ready = s.instr_ready;
  assign exec_done = s.exec_done;
  assign program_counter = s.pc;
  assign stack_push = s.stack_push;
  assign return_stack_head = s.stack_head;
  assign file_wr_en = s.file_wr_en;
  assign file_wr_addr = s.file_wr_addr;
  assign file_wr_data = 8'h00;
  assign accumulator = s.acc;
  assign zero_flag = s.status[cci_pkg::ST_ZERO];
  assign watchdog_expiry_bit = s.status[cci_pkg::ST_EXPIRY];
  assign sleep_entry_bit = s.status[cci_pkg::ST_SLEEP];
  assign watchdog_timeout = wdt_timeout;
  assign reg_rdata = s.rdata;

endmodule : cci_exec

`default_nettype wire

// ---- rtl/cci_pkg.sv ----
// constants, opcodes, field layouts and register map of the call and clear execution block
// assumes one core clock; all users reference names as cci_pkg::name
`default_nettype none

package cci_pkg;

  // widths
  localparam int PC_W = 11;
  localparam int DATA_W = 8;
  localparam int WORD_W = 12;
  localparam int FILE_ADDR_W = 5;
  localparam int BUS_ADDR_W = 4;

  // opcode patterns and masks of the handled instructions
  localparam logic [11:0] CALL_MASK = 12'hF00;
  localparam logic [11:0] CALL_CODE = 12'h900;
  localparam logic [11:0] FILE_WIPE_MASK = 12'hFE0;
  localparam logic [11:0] FILE_WIPE_CODE = 12'h060;
  localparam logic [11:0] ACC_WIPE_CODE = 12'h040;
  localparam logic [11:0] WDT_RESTART_CODE = 12'h004;

  // operand field positions inside the program word
  localparam int IMM_MSB = 7;
  localparam int IMM_LSB = 0;
  localparam int FILE_MSB = 4;
  localparam int FILE_LSB = 0;

  // status bit positions
  localparam int ST_PAGE_HI = 6;
  localparam int ST_PAGE_LO = 5;
  localparam int ST_EXPIRY = 4;
  localparam int ST_SLEEP = 3;
  localparam int ST_ZERO = 2;

  // control bit position: prescaler belongs to the watchdog
  localparam int CTL_PSC_WDT = 0;

  // register offsets on the plain register port
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CONTROL = 4'h1;
  localparam logic [3:0] REG_ACCUM = 4'h2;
  localparam logic [3:0] REG_PC_LO = 4'h3;
  localparam logic [3:0] REG_PC_HI = 4'h4;
  localparam logic [3:0] REG_STACK_LO = 4'h5;
  localparam logic [3:0] REG_STACK_HI = 4'h6;
  localparam logic [3:0] REG_WDT_COUNT = 4'h7;

  // reset values
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] CONTROL_RST = 8'h01;
  localparam logic [7:0] ACCUM_RST = 8'h00;
  localparam logic [10:0] PC_RST = 11'h000;
  localparam logic [7:0] WDT_COUNT_RST = 8'h00;

  // watchdog pacing defaults
  localparam int WDT_PRESCALE_DEF = 128;
  localparam logic [7:0] WDT_LIMIT = 8'hFF;

  // execution phase
  typedef enum logic [0:0] {
    PH_EXEC = 1'b0,
    PH_CALL_SECOND = 1'b1
  } cci_phase_type;

  // opcode recognisers and operand extraction
  function automatic logic cci_is_call(input logic [11:0] w);
    return (w & CALL_MASK) == CALL_CODE;
  endfunction : cci_is_call

  function automatic logic cci_is_file_wipe(input logic [11:0] w);
    return (w & FILE_WIPE_MASK) == FILE_WIPE_CODE;
  endfunction : cci_is_file_wipe

  function automatic logic [4:0] cci_file_addr(input logic [11:0] w);
    return w[FILE_MSB:FILE_LSB];
  endfunction : cci_file_addr

endpackage : cci_pkg

`default_nettype wire

// ---- rtl/cci_watchdog.sv ----
// watchdog counter with an optional prescaler in front of it
// assumes restart strobes come from logic on the same clock
`default_nettype none

module cci_watchdog #(
  parameter int PRESCALE = cci_pkg::WDT_PRESCALE_DEF
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic counter_restart,
  input wire logic prescaler_restart,
  input wire logic prescaler_assigned,
  output logic [7:0] watchdog_counter,
  output logic timeout
);

  localparam int PSC_W = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
  localparam logic [PSC_W-1:0] PSC_LAST = PSC_W'(PRESCALE - 1);

  typedef struct packed {
    logic [PSC_W-1:0] prescaler;
    logic [7:0] count;
    logic timeout;
  } cci_wdt_state_type;

  cci_wdt_state_type s;
  cci_wdt_state_type next_s;
  logic tick;

  // prescaler and counter advance, restart has priority
  always_comb
  begin
    next_s = s;
    next_s.timeout = 1'b0;
    tick = 1'b1;
    if (prescaler_assigned)
    begin
      tick = (s.prescaler == PSC_LAST);
      next_s.prescaler = tick ? '0 : s.prescaler + 1'b1;
    end
    if (prescaler_restart)
    begin
      next_s.prescaler = '0;
    end
    if (tick)
    begin
      if (s.count == cci_pkg::WDT_LIMIT)
      begin
        next_s.count = cci_pkg::WDT_COUNT_RST;
        next_s.timeout = 1'b1;
      end
      else
      begin
        next_s.count = s.count + 8'h01;
      end
    end
    if (counter_restart)
    begin
      next_s.count = cci_pkg::WDT_COUNT_RST;
      next_s.timeout = 1'b0;
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s <= '{prescaler: '0, count: cci_pkg::WDT_COUNT_RST, timeout: 1'b0};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign watchdog_counter = s.count;
  assign timeout = s.timeout;

endmodule : cci_watchdog

`default_nettype wire

// ---- tb/cci_exec_props.sv ----
// port checker for the call and clear execution block
// assumes one clock mclk and asynchronous active low rstn
`default_nettype none

module cci_exec_props (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic instr_valid,
  input wire logic [11:0] instr_word,
  input wire logic instr_ready,
  input wire logic exec_done,
  input wire logic [10:0] program_counter,
  input wire logic stack_push,
  input wire logic [10:0] return_stack_head,
  input wire logic file_wr_en,
  input wire logic [4:0] file_wr_addr,
  input wire logic [7:0] file_wr_data,
  input wire logic [7:0] accumulator,
  input wire logic zero_flag,
  input wire logic watchdog_expiry_bit,
  input wire logic sleep_entry_bit
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic take;
  logic call;
  logic wipe;
  logic wdt;
  // words taken at this edge, by kind
  assign take = instr_valid && instr_ready;
  assign call = take && ((instr_word & cci_pkg::CALL_MASK) == cci_pkg::CALL_CODE);
  assign wipe = take && ((instr_word & cci_pkg::FILE_WIPE_MASK) == cci_pkg::FILE_WIPE_CODE);
  assign wdt = take && (instr_word == cci_pkg::WDT_RESTART_CODE);
  property p_imm;
    logic [7:0] k;
    (call, k = instr_word[7:0]) |=> program_counter[7:0] == k && !program_counter[8];
  endproperty
  property p_faddr;
    logic [4:0] f;
    (wipe, f = instr_word[4:0]) |=> file_wr_addr == f;
  endproperty
  a_call_push: assert property (call |=> stack_push && return_stack_head == $past(program_counter) + 11'h001)
    else $error("return address wrong");
  a_call_imm: assert property (p_imm)
    else $error("call target wrong");
  a_call_slot: assert property (call |=> !instr_ready ##1 (instr_ready && exec_done))
    else $error("call length wrong");
  a_call_flags: assert property (call |=> $stable(zero_flag) && $stable(sleep_entry_bit))
    else $error("call changed flags");
  a_file_wipe: assert property (wipe |=> file_wr_en && file_wr_data == 8'h00 && zero_flag && exec_done)
    else $error("file wipe wrong");
  a_file_addr: assert property (p_faddr)
    else $error("file address wrong");
  a_acc_wipe: assert property (take && instr_word == cci_pkg::ACC_WIPE_CODE |=> accumulator == 8'h00 && zero_flag)
    else $error("accumulator wipe wrong");
  a_wdt_bits: assert property (wdt |=> watchdog_expiry_bit && sleep_entry_bit)
    else $error("restart flags wrong");
  a_one_word: assert property (take && !call |=> exec_done && instr_ready && !stack_push)
    else $error("single cycle word wrong");
  c_call: cover property (call);
  c_wipe: cover property (wipe);
  c_wdt: cover property (wdt);
endmodule : cci_exec_props

bind cci_exec cci_exec_props u_props (.mclk, .rstn, .instr_valid, .instr_word, .instr_ready, .exec_done,
  .program_counter, .stack_push, .return_stack_head, .file_wr_en, .file_wr_addr, .file_wr_data,
  .accumulator, .zero_flag, .watchdog_expiry_bit, .sleep_entry_bit);

`default_nettype wire

// ---- tb/cci_core_model.sv ----
// program memory and register file facing the execution block
// assumes the word is fetched at the address on program_counter
`default_nettype none

module cci_core_model (
  input wire logic mclk,
  input wire logic run,
  input wire logic [10:0] program_counter,
  input wire logic file_wr_en,
  input wire logic [4:0] file_wr_addr,
  input wire logic [7:0] file_wr_data,
  output logic instr_valid,
  output logic [11:0] instr_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] prog [0:2047];
  logic [7:0] regs [0:31];
  // empty memory holds no-ops, files hold a marker
  initial
  begin
    foreach (prog[i]) prog[i] = 12'h000;
    foreach (regs[i]) regs[i] = 8'hA5;
  end
  // one whole word per fetch, inverted while not offered
  assign instr_valid = run;
  assign instr_word = run ? prog[program_counter] : ~prog[program_counter];
  // file register write port
  always @(posedge mclk)
    if (file_wr_en) regs[file_wr_addr] <= file_wr_data;
endmodule : cci_core_model

`default_nettype wire

// ---- tb/cci_exec_test.sv ----
// self-checking bench for the call and clear execution block
// assumes a 250 MHz mclk and the memory model beside the block
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; $display("MISMATCH %0t %h %h", $time, g, e); end end

module cci_exec_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rstn, run, reg_wr, reg_rd, instr_valid, instr_ready, exec_done, stack_push, file_wr_en;
  logic zero_flag, watchdog_expiry_bit, sleep_entry_bit, watchdog_timeout;
  logic [11:0] instr_word;
  logic [10:0] program_counter, return_stack_head, call_pc;
  logic [4:0] file_wr_addr;
  logic [7:0] file_wr_data, accumulator, reg_wdata, reg_rdata, rd;
  logic [3:0] reg_addr;
  int bad_count, checks_done, n;

  cci_exec #(.WDT_PRESCALE(2)) dut (.mclk, .rstn, .instr_valid, .instr_word, .instr_ready, .exec_done,
    .program_counter, .stack_push, .return_stack_head, .file_wr_en, .file_wr_addr, .file_wr_data,
    .accumulator, .zero_flag, .watchdog_expiry_bit, .sleep_entry_bit, .watchdog_timeout,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  cci_core_model mdl (.mclk, .run, .program_counter, .file_wr_en, .file_wr_addr, .file_wr_data,
    .instr_valid, .instr_word);

  // free running clock
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // program counter seen in the cycle of the return push
  always @(posedge mclk)
    if (stack_push) call_pc <= program_counter;

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_get(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask : reg_get

  task automatic wrap_up();
    if (bad_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // hang guard, far beyond the few hundred cycles used
  initial
  begin
    #20000;
    bad_count++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    rstn = 1'b0;
    run = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    reg_get(cci_pkg::REG_STATUS);
    `CHK(rd, 8'h18)
    reg_get(4'h8);
    `CHK(rd, 8'h00)
    reg_write(cci_pkg::REG_CONTROL, 8'h00);
    reg_write(cci_pkg::REG_STATUS, 8'h60);
    reg_write(cci_pkg::REG_ACCUM, 8'h5A);
    mdl.prog[0] = 12'h06F;
    mdl.prog[1] = 12'h040;
    mdl.prog[2] = 12'h9AB;
    mdl.prog[11'h6AB] = 12'h004;
    repeat (100) @(posedge mclk);
    @(posedge mclk);
    run <= 1'b1;
    n = 0;
    // five cycles hold four completions only if the call takes two
    repeat (5)
    begin
      @(posedge mclk);
      #1;
      if (exec_done === 1'b1) n++;
    end
    @(posedge mclk);
    run <= 1'b0;
    #1;
    `CHK(n, 4)
    `CHK(call_pc, 11'h6AB)
    `CHK(return_stack_head, 11'h003)
    `CHK(mdl.regs[15], 8'h00)
    `CHK(accumulator, 8'h00)
    `CHK(watchdog_expiry_bit, 1'b1)
    `CHK(sleep_entry_bit, 1'b1)
    reg_get(cci_pkg::REG_STACK_LO);
    `CHK(rd, 8'h03)
    reg_get(cci_pkg::REG_STATUS);
    `CHK(rd, 8'h7C)
    reg_get(cci_pkg::REG_WDT_COUNT);
    `CHK(rd, 8'h05)
    // second pass: prescaler assigned, restart one word in, call from a page with bit 8 set
    reg_write(cci_pkg::REG_CONTROL, 8'h01);
    mdl.prog[11'h6AE] = 12'h004;
    mdl.prog[11'h700] = 12'h9C3;
    run <= 1'b1;
    repeat (91) @(posedge mclk);
    run <= 1'b0;
    #1;
    `CHK(call_pc, 11'h6C3)
    `CHK(return_stack_head, 11'h701)
    reg_get(cci_pkg::REG_WDT_COUNT);
    `CHK(rd, 8'h2C)
    wrap_up();
  end
endmodule : cci_exec_test

`default_nettype wire
